// [rtl/pbs_pkg.sv]
package pbs_pkg;
	// bus command codes
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	// target decode window
	localparam logic [31:0] TGT_BASE = 32'h0001_0000;
	localparam logic [31:0] TGT_MASK = 32'hFFFF_FFF0;
	localparam int MEM_WORDS = 4;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 2;
	// timing: clock rate in MHz, devsel wait in ns, and the counts in bus clocks
	localparam int CLK_MHZ = 40;
	localparam int DEVSEL_WAIT_NS = 200;
	localparam logic [3:0] DEVSEL_WAIT = 4'((DEVSEL_WAIT_NS * CLK_MHZ) / 1000);
	localparam logic [1:0] READY_GAP = 2'h2;
	localparam logic [1:0] CLKRUN_HOLD = 2'h2;
	localparam logic [1:0] SYNC_SETTLE = 2'h2;

	// initiator request from the user side
	typedef struct packed {
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [3:0] byteEn_n;
		logic [31:0] data;
		logic [1:0] lastIdx;
	} pbs_req_t;

	// sampled bus pins
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic frame_n;
		logic irdy_n;
		logic trdy_n;
		logic devsel_n;
		logic clkrun_n;
	} pbs_bus_t;

	typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_GAP, M_TURN} pbs_mst_t;
	typedef enum logic [2:0] {T_IDLE, T_CLAIM, T_DATA, T_GAP, T_TURN} pbs_tgt_t;
endpackage

// [rtl/pbs_pci_bus.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - address phase puts the 32-bit address on the shared lines
// - data phases reuse the same lines for data words
// - initiator drives command in address phase, target decodes it
// - during data phases the four command lines are active-low byte enables
// - as target, assert device select to claim an address that hits
// - as initiator, no device select before time-out gives master abort
// - only the initiator drives frame, asserting it at the start
// - frame stays asserted while more data phases follow
// - frame released marks the last data phase; target finishes after it
// - clock-run pin is only pulled low or released
// - a data phase completes only when both ready lines are low
// - every bus input is sampled on the rising bus clock edge
module pbs_pci_bus
	import pbs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// address/data pins
	input wire logic [31:0] adIn,
	output logic [31:0] adOut,
	output logic adOe_n,
	// command/byte-enable pins
	input wire logic [3:0] cbeIn,
	output logic [3:0] cbeOut,
	output logic cbeOe_n,
	// framing and handshake pins
	input wire logic frameIn_n,
	output logic frameOut_n,
	output logic frameOe_n,
	input wire logic irdyIn_n,
	output logic irdyOut_n,
	output logic irdyOe_n,
	input wire logic trdyIn_n,
	output logic trdyOut_n,
	output logic trdyOe_n,
	input wire logic devselIn_n,
	output logic devselOut_n,
	output logic devselOe_n,
	// clock-run pin, open drain
	input wire logic clkrunIn_n,
	output logic clkrunOut_n,
	output logic clkrunOe_n,
	// initiator user side
	input wire pbs_req_t mstReq,
	input wire logic mstReqValid,
	output logic mstReqReady,
	output logic [31:0] mstRdData,
	output logic mstRdValid,
	output logic mstDone,
	output logic mstAbort,
	// target and clock user side
	input wire logic keepClock,
	output logic tgtBusy
);

	pbs_bus_t pinsNow, sync1_r, sync2_r;
	pbs_mst_t mst_r;
	pbs_tgt_t tgt_r;
	pbs_req_t req_r;
	logic [1:0] mstIdx_r, mstGap_r, tgtGap_r, crHold_r;
	logic [3:0] waitCnt_r;
	logic mstIrdy_r, claimed_r, prevFrame_r, isRead_r, tgtTrdy_r;
	logic [IDX_W-1:0] tgtIdx_r;
	logic [31:0] mem_r [MEM_WORDS];
	logic busStart, tgtHit, tgtXfer, mstXfer, mstLast;

	assign pinsNow = '{ad: adIn, cbe: cbeIn, frame_n: frameIn_n, irdy_n: irdyIn_n,
		trdy_n: trdyIn_n, devsel_n: devselIn_n, clkrun_n: clkrunIn_n};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_r <= '1;
			sync2_r <= '1;
		end else begin
			sync1_r <= pinsNow;
			sync2_r <= sync1_r;
		end
	end

	// frame edge tracker for the target
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prevFrame_r <= 1'b1;
		end else begin
			prevFrame_r <= sync2_r.frame_n;
		end
	end

	assign busStart = prevFrame_r && !sync2_r.frame_n && (mst_r == M_IDLE);
	assign tgtHit = ((sync2_r.ad & TGT_MASK) == TGT_BASE)
		&& ((sync2_r.cbe == CMD_MEM_RD) || (sync2_r.cbe == CMD_MEM_WR));
	// completion needs both ready lines low
	assign tgtXfer = (tgt_r == T_DATA) && !tgtTrdy_r && !sync2_r.irdy_n;
	assign mstXfer = (mst_r == M_DATA) && !mstIrdy_r && !sync2_r.trdy_n;
	assign mstLast = (mstIdx_r == req_r.lastIdx);

	// initiator sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mst_r <= M_IDLE;
			req_r <= '0;
			mstIdx_r <= '0;
			mstGap_r <= '0;
			waitCnt_r <= '0;
			claimed_r <= 1'b0;
			mstIrdy_r <= 1'b1;
		end else begin
			unique case (mst_r)
				M_IDLE: begin
					if (mstReqValid && mstReqReady) begin
						req_r <= mstReq;
						mstIdx_r <= '0;
						waitCnt_r <= '0;
						claimed_r <= 1'b0;
						mst_r <= M_ADDR;
					end
				end
				M_ADDR: begin
					mstIrdy_r <= 1'b0;
					mst_r <= M_DATA;
				end
				M_DATA: begin
					if (!sync2_r.devsel_n) begin
						claimed_r <= 1'b1;
					end
					if (!claimed_r && sync2_r.devsel_n) begin
						waitCnt_r <= waitCnt_r + 4'h1;
					end
					// no claim in time ends the cycle
					if (!claimed_r && sync2_r.devsel_n && waitCnt_r >= DEVSEL_WAIT) begin
						mstIrdy_r <= 1'b1;
						mst_r <= M_TURN;
					end else if (mstXfer) begin
						mstIrdy_r <= 1'b1;
						mstGap_r <= READY_GAP;
						mst_r <= mstLast ? M_TURN : M_GAP;
					end
				end
				M_GAP: begin
					mstGap_r <= mstGap_r - 2'h1;
					if (mstGap_r == 2'h1) begin
						mstIdx_r <= mstIdx_r + 2'h1;
						mstIrdy_r <= 1'b0;
						mst_r <= M_DATA;
					end
				end
				M_TURN: begin
					mst_r <= M_IDLE;
				end
				default: mst_r <= M_IDLE;
			endcase
		end
	end

	// initiator user answers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mstReqReady <= 1'b0;
			mstRdData <= '0;
			mstRdValid <= 1'b0;
			mstDone <= 1'b0;
			mstAbort <= 1'b0;
		end else begin
			mstReqReady <= (mst_r == M_IDLE) && !(mstReqValid && mstReqReady)
				&& (tgt_r == T_IDLE) && sync2_r.frame_n && sync2_r.irdy_n;
			mstRdValid <= mstXfer && (req_r.cmd == CMD_MEM_RD);
			if (mstXfer) begin
				mstRdData <= sync2_r.ad;
			end
			mstDone <= mstXfer && mstLast;
			mstAbort <= (mst_r == M_DATA) && !claimed_r && sync2_r.devsel_n
				&& (waitCnt_r >= DEVSEL_WAIT);
		end
	end

	// target sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tgt_r <= T_IDLE;
			tgtIdx_r <= '0;
			tgtGap_r <= '0;
			isRead_r <= 1'b0;
			tgtTrdy_r <= 1'b1;
		end else begin
			unique case (tgt_r)
				T_IDLE: begin
					if (busStart && tgtHit) begin
						tgtIdx_r <= sync2_r.ad[IDX_LSB +: IDX_W];
						isRead_r <= (sync2_r.cbe == CMD_MEM_RD);
						tgt_r <= T_CLAIM;
					end
				end
				T_CLAIM: begin
					tgtTrdy_r <= 1'b0;
					tgt_r <= T_DATA;
				end
				T_DATA: begin
					if (tgtXfer) begin
						tgtTrdy_r <= 1'b1;
						tgtGap_r <= SYNC_SETTLE;
						tgtIdx_r <= tgtIdx_r + 1'b1;
						// frame high at completion ends it
						tgt_r <= sync2_r.frame_n ? T_TURN : T_GAP;
					end
				end
				T_GAP: begin
					tgtGap_r <= tgtGap_r - 2'h1;
					if (tgtGap_r == 2'h1) begin
						tgtTrdy_r <= 1'b0;
						tgt_r <= T_DATA;
					end
				end
				T_TURN: begin
					tgt_r <= T_IDLE;
				end
				default: tgt_r <= T_IDLE;
			endcase
		end
	end

	// target storage, per-lane writes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int w = 0; w < MEM_WORDS; w++) begin
				mem_r[w] <= '0;
			end
		end else if (tgtXfer && !isRead_r) begin
			for (int b = 0; b < 4; b++) begin
				if (!sync2_r.cbe[b]) begin
					mem_r[tgtIdx_r][8*b +: 8] <= sync2_r.ad[8*b +: 8];
				end
			end
		end
	end

	// address/data and command drivers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			adOut <= '0;
			adOe_n <= 1'b1;
			cbeOut <= '0;
			cbeOe_n <= 1'b1;
		end else begin
			adOe_n <= 1'b1;
			cbeOe_n <= 1'b1;
			if (mst_r == M_IDLE && mstReqValid && mstReqReady) begin
				// address and command for the address phase
				adOut <= mstReq.addr;
				adOe_n <= 1'b0;
				cbeOut <= mstReq.cmd;
				cbeOe_n <= 1'b0;
			end else if (mst_r == M_ADDR || mst_r == M_DATA || mst_r == M_GAP) begin
				// data words on the same lines
				adOut <= req_r.data;
				adOe_n <= (req_r.cmd == CMD_MEM_RD);
				cbeOut <= req_r.byteEn_n;
				cbeOe_n <= 1'b0;
			end else if (tgt_r == T_CLAIM || tgt_r == T_DATA || tgt_r == T_GAP) begin
				// read data only after the turnaround
				adOut <= mem_r[tgtIdx_r];
				adOe_n <= !isRead_r;
			end
		end
	end

	// frame and initiator ready drivers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			frameOut_n <= 1'b1;
			frameOe_n <= 1'b1;
			irdyOut_n <= 1'b1;
			irdyOe_n <= 1'b1;
		end else begin
			frameOe_n <= !((mst_r == M_IDLE && mstReqValid && mstReqReady)
				|| mst_r == M_ADDR || mst_r == M_DATA || mst_r == M_GAP || mst_r == M_TURN);
			// held low until the last phase
			if (mst_r == M_IDLE) begin
				frameOut_n <= !(mstReqValid && mstReqReady);
			end else if (mst_r == M_DATA && irdyOut_n && !mstIrdy_r) begin
				frameOut_n <= mstLast;
			end else if (mst_r == M_TURN) begin
				frameOut_n <= 1'b1;
			end
			irdyOut_n <= mstIrdy_r;
			// driven high one cycle before release
			irdyOe_n <= (mst_r == M_IDLE);
		end
	end

	// target claim and ready drivers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			devselOut_n <= 1'b1;
			devselOe_n <= 1'b1;
			trdyOut_n <= 1'b1;
			trdyOe_n <= 1'b1;
			tgtBusy <= 1'b0;
		end else begin
			devselOut_n <= !(tgt_r == T_CLAIM || tgt_r == T_DATA || tgt_r == T_GAP);
			devselOe_n <= (tgt_r == T_IDLE);
			trdyOut_n <= tgtTrdy_r;
			trdyOe_n <= (tgt_r == T_IDLE);
			tgtBusy <= (tgt_r != T_IDLE);
		end
	end

	// clock-run: pull low only, never drive high
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			crHold_r <= '0;
			clkrunOut_n <= 1'b0;
			clkrunOe_n <= 1'b1;
		end else begin
			clkrunOut_n <= 1'b0;
			if (crHold_r != 2'h0) begin
				crHold_r <= crHold_r - 2'h1;
			end else if (sync2_r.clkrun_n && clkrunOe_n
				&& (keepClock || mst_r != M_IDLE || tgt_r != T_IDLE)) begin
				crHold_r <= CLKRUN_HOLD;
			end
			clkrunOe_n <= (crHold_r == 2'h0);
		end
	end

endmodule
`default_nettype wire

// [tb/pbs_pci_bus_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pbs_pci_bus_props
	import pbs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pin levels
	input wire logic [31:0] adIn,
	input wire logic [3:0] cbeIn,
	input wire logic frameIn_n,
	input wire logic devselIn_n,
	// pin drives
	input wire logic [31:0] adOut,
	input wire logic adOe_n,
	input wire logic [3:0] cbeOut,
	input wire logic frameOut_n,
	input wire logic frameOe_n,
	input wire logic irdyOut_n,
	input wire logic trdyOut_n,
	input wire logic trdyOe_n,
	input wire logic devselOut_n,
	input wire logic devselOe_n,
	input wire logic clkrunOut_n,
	input wire logic clkrunOe_n,
	// initiator user side
	input wire pbs_req_t mstReq,
	input wire logic mstReqValid,
	input wire logic mstReqReady,
	input wire logic mstAbort
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_reset_idle: assert property ($rose(rst_n) |-> frameOe_n && adOe_n && devselOe_n)
		else $error("drivers not idle after reset");
	chk_start_frame: assert property (mstReqValid && mstReqReady |=>
		!mstReqReady && !frameOe_n && !frameOut_n) else $error("frame start");
	chk_addr_phase: assert property (mstReqValid && mstReqReady |=> !adOe_n &&
		adOut == $past(mstReq.addr) && cbeOut == $past(mstReq.cmd)) else $error("address phase");
	chk_last_irdy: assert property ($rose(frameOut_n) && !frameOe_n |-> !irdyOut_n)
		else $error("last phase without ready");
	chk_clkrun_od: assert property (!clkrunOe_n |-> !clkrunOut_n)
		else $error("clock run driven high");
	chk_trdy_claim: assert property (!trdyOe_n && !trdyOut_n |-> !devselOe_n && !devselOut_n)
		else $error("ready without claim");
	chk_claim_hit: assert property ($fell(frameIn_n) && frameOe_n && cbeIn == CMD_MEM_WR &&
		(adIn & TGT_MASK) == TGT_BASE |-> ##[1:6] !devselOe_n && !devselOut_n)
		else $error("hit not claimed");
	chk_no_claim: assert property ($fell(frameIn_n) && (adIn & TGT_MASK) != TGT_BASE |->
		devselOe_n [*6]) else $error("miss claimed");
	chk_abort_wait: assert property (mstAbort |-> devselIn_n && $past(devselIn_n, 8))
		else $error("early abort");
	chk_frame_only: assert property (!frameOe_n |-> devselOe_n && trdyOe_n)
		else $error("two roles at once");
endmodule
bind pbs_pci_bus pbs_pci_bus_props pbs_pci_bus_props_inst(.clk_sys, .rst_n, .adIn, .cbeIn,
	.frameIn_n, .devselIn_n, .adOut, .adOe_n, .cbeOut, .frameOut_n, .frameOe_n, .irdyOut_n,
	.trdyOut_n, .trdyOe_n, .devselOut_n, .devselOe_n, .clkrunOut_n, .clkrunOe_n, .mstReq,
	.mstReqValid, .mstReqReady, .mstAbort);
`default_nettype wire

// [tb/pbs_agent_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pbs_agent_model
	import pbs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// bus lines seen
	input wire logic frameN,
	input wire logic irdyN,
	input wire logic [3:0] cbe,
	// behaviour
	input wire logic claim,
	input wire logic [1:0] lat,
	input wire logic [31:0] rdWord,
	// drives
	output logic devselN,
	output logic trdyN,
	output logic oeN,
	output logic adOeN,
	output logic [31:0] adDrv
);
	logic [1:0] st, cnt;
	logic fPrev, isRd;

	assign adDrv = rdWord;
	// target role, sampled on rising edge
	always_ff @(posedge clk_sys) begin
		fPrev <= frameN;
		cnt <= cnt + 2'h1;
		if (!rst_n) begin
			st <= 2'h0;
			cnt <= 2'h0;
			oeN <= 1'b1;
			adOeN <= 1'b1;
			devselN <= 1'b1;
			trdyN <= 1'b1;
		end else case (st)
			2'h0: if (fPrev && !frameN && claim) begin
				st <= 2'h1;
				oeN <= 1'b0;
				devselN <= 1'b0;
				isRd <= cbe == CMD_MEM_RD;
				cnt <= 2'h0;
			end else begin
				oeN <= 1'b1;
			end
			// data phases, last when frame high
			2'h1: if (!trdyN && !irdyN) begin
				trdyN <= 1'b1;
				cnt <= 2'h0;
				if (frameN) st <= 2'h2;
			end else if (cnt >= lat && cnt >= 2'h2) begin // gap covers sampled-ready lag
				trdyN <= 1'b0;
				adOeN <= !isRd;
			end
			// drive high one cycle, then release
			default: begin
				devselN <= 1'b1;
				adOeN <= 1'b1;
				st <= 2'h0;
			end
		endcase
	end
endmodule
`default_nettype wire

// [tb/pbs_pci_bus_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pbs_pci_bus_tb
	import pbs_pkg::*;
;
	logic clk_sys = 0, rst_n = 0, bOe = 0, bAdOe = 0, bFrm = 1, bIrdy = 1;
	logic claim = 0, keepClock = 0, mstReqValid = 0, pDev, pTrdy, pOe, pAdOe;
	logic [1:0] lat = 0;
	logic [3:0] bCbe = 0, cbeOut;
	logic [31:0] bAd = 0, pWord = 0, wD, lastD, rdD, adOut, mstRdData, pAd;
	logic [31:0] seed = 32'hC9FF3979;
	logic [31:0] mem [4];
	logic adOe_n, cbeOe_n, frameOut_n, frameOe_n, irdyOut_n, irdyOe_n, trdyOut_n, trdyOe_n;
	logic devselOut_n, devselOe_n, clkrunOut_n, clkrunOe_n, mstReqReady, mstRdValid;
	logic mstDone, mstAbort, tgtBusy, bz;
	pbs_req_t mstReq = '0;
	int fail_count = 0, n_tests = 0, nPh = 0, nRd = 0;
	// wire levels from all drivers, pulled-up lines float high
	wire logic frameIn_n = !frameOe_n ? frameOut_n : bOe ? bFrm : 1'b1;
	wire logic irdyIn_n = !irdyOe_n ? irdyOut_n : bOe ? bIrdy : 1'b1;
	wire logic trdyIn_n = !trdyOe_n ? trdyOut_n : !pOe ? pTrdy : 1'b1;
	wire logic devselIn_n = !devselOe_n ? devselOut_n : !pOe ? pDev : 1'b1;
	wire logic [31:0] adIn = !adOe_n ? adOut : bAdOe ? bAd : !pAdOe ? pAd : ~adOut;
	wire logic [3:0] cbeIn = !cbeOe_n ? cbeOut : bOe ? bCbe : ~cbeOut;
	wire logic clkrunIn_n = clkrunOe_n | clkrunOut_n;

	pbs_pci_bus pbs_pci_bus_inst(.clk_sys, .rst_n, .adIn, .adOut, .adOe_n, .cbeIn, .cbeOut,
		.cbeOe_n, .frameIn_n, .frameOut_n, .frameOe_n, .irdyIn_n, .irdyOut_n, .irdyOe_n,
		.trdyIn_n, .trdyOut_n, .trdyOe_n, .devselIn_n, .devselOut_n, .devselOe_n, .clkrunIn_n,
		.clkrunOut_n, .clkrunOe_n, .mstReq, .mstReqValid, .mstReqReady, .mstRdData,
		.mstRdValid, .mstDone, .mstAbort, .keepClock, .tgtBusy);
	pbs_agent_model pbs_agent_model_inst(.clk_sys, .rst_n, .frameN(frameIn_n),
		.irdyN(irdyIn_n), .cbe(cbeIn), .claim, .lat, .rdWord(pWord), .devselN(pDev),
		.trdyN(pTrdy), .oeN(pOe), .adOeN(pAdOe), .adDrv(pAd));

	always #12.5 clk_sys = ~clk_sys;
	// completed phases and read pulses
	always @(posedge clk_sys) begin
		if (irdyIn_n === 0 && trdyIn_n === 0) begin
			nPh++;
			lastD = adIn;
		end
		if (mstRdValid === 1) begin
			nRd++;
			rdD = mstRdData;
		end
	end

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			if (!be[b]) o[b * 8 +: 8] = n[b * 8 +: 8];
		return o;
	endfunction
	task chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task final_report();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one-phase cycle with the block as target
	task automatic tcyc(input logic [31:0] a, input logic [3:0] c, be, input logic [31:0] d,
		output logic h, output logic [31:0] rd);
		h = 0;
		@(posedge clk_sys);
		bOe <= 1;
		bAdOe <= 1;
		bFrm <= 0;
		bAd <= a;
		bCbe <= c;
		@(posedge clk_sys);
		bFrm <= 1;
		bIrdy <= 0;
		bAd <= d;
		bCbe <= be;
		bAdOe <= c != CMD_MEM_RD;
		for (int k = 0; k < 12 && !h; k++) begin
			@(posedge clk_sys);
			h = trdyIn_n === 0 && devselIn_n === 0;
			rd = adIn;
			bz = tgtBusy;
		end
		bIrdy <= 1;
		bAdOe <= 0;
		@(posedge clk_sys);
		bOe <= 0;
		repeat (6) @(posedge clk_sys);
	endtask
	// cycle started by the block; res is {abort, done}
	task automatic mreq(input logic [3:0] c, input logic [1:0] n, output logic [1:0] res);
		wD = rnd();
		nPh = 0;
		nRd = 0;
		pWord <= rnd();
		mstReq <= '{c, rnd(), 4'h0, wD, n};
		for (int k = 0; k < 40 && mstReqReady !== 1; k++) @(posedge clk_sys);
		mstReqValid <= 1;
		@(posedge clk_sys);
		mstReqValid <= 0;
		res = 0;
		for (int k = 0; k < 80 && res == 0; k++) begin
			@(posedge clk_sys);
			res = {mstAbort === 1, mstDone === 1};
		end
		repeat (8) @(posedge clk_sys);
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		final_report();
	end
	// main sequence
	initial begin
		logic h;
		logic [1:0] r;
		logic [3:0] be;
		logic [31:0] g, d, a;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1;
		repeat (4) @(posedge clk_sys);
		for (int j = 0; j < 4; j++) begin
			mem[j] = rnd();
			tcyc(TGT_BASE + 32'(j * 4), CMD_MEM_WR, 4'h0, mem[j], h, g);
			chk("wr claim", 1, h);
			chk("wr busy", 1, bz);
		end
		for (int j = 0; j < 8; j++) begin
			be = 4'(rnd());
			d = rnd();
			a = TGT_BASE + 32'(j % 4 * 4);
			tcyc(a, CMD_MEM_WR, be, d, h, g);
			mem[j % 4] = merge(mem[j % 4], d, be);
			tcyc(a, CMD_MEM_RD, 4'h0, 32'h0, h, g);
			chk("tgt rd", mem[j % 4], g);
		end
		for (int j = 2; j < 8; j++) begin
			tcyc(TGT_BASE, 4'(j), 4'h0, 32'h0, h, g);
			chk("cmd claim", j > 5, h);
		end
		tcyc(TGT_BASE + 32'h100, CMD_MEM_WR, 4'h0, 32'h0, h, g);
		chk("miss", 0, h);
		chk("miss busy", 0, bz);
		$display("target tests done");
		claim <= 1;
		for (int j = 0; j < 4; j++) begin
			lat <= 2'(rnd());
			mreq(CMD_MEM_WR, 2'(j), r);
			chk("wr done", 1, r);
			chk("wr data", wD, lastD);
			chk("wr phases", j + 1, nPh);
			mreq(CMD_MEM_RD, 2'(j), r);
			chk("rd data", pWord, rdD);
			chk("rd count", j + 1, nRd);
		end
		claim <= 0;
		mreq(CMD_MEM_WR, 2'h0, r);
		chk("abort", 2, r);
		$display("initiator tests done");
		keepClock <= 1;
		for (int k = 0; k < 8 && clkrunOe_n !== 0; k++) @(posedge clk_sys);
		chk("clkrun", 0, clkrunOe_n);
		$display("clock run test done");
		final_report();
	end
endmodule
`default_nettype wire
